// ==== logic/adcc_top.sv ====
// adcc_top: converter control with AXI4-Lite registers.
// assumes the analog mux and comparator sit outside, and that other
// interrupt sources arrive as levels on other_irq_req.
//
// Notes on behaviour
// - writing start launches one conversion
// - start reads one while busy, self-clears
// - done flag set by hardware, cleared by software
// - interrupt raised while done and enable set
// - three-bit select picks input n
// - start on unmapped input does nothing
// - map bit hands the pin to converter
// - conversion lasts eleven converter clocks
// - precision start halts the CPU
// - only end-of-conversion interrupt wakes CPU
// - other interrupts held until conversion interrupt wakes CPU
// - standard gives 8 bits, precision 10
// - unsigned linear code, saturating at ends
// - converter clock from prescaler on bus clock
// - power bit clear puts converter in standby
// - upper result bits 9-2, lower bits 1-0
`timescale 1ns/1ps
module adcc_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic comp_above,
    input wire logic [7:0] other_irq_req,
    output logic [9:0] trial_code,
    output logic sample_hold,
    output logic [2:0] sampled_input,
    output logic [7:0] input_enable_bits,
    output logic converter_power_on,
    output logic conv_irq,
    output logic cpu_halt,
    output logic [7:0] other_irq_fwd
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic aw_held_q, w_held_q;
    logic [9:0] aw_idx_q;
    logic [7:0] wbyte_q;
    logic wlane_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic [2:0] sel_q, chan_q;
    logic start_q, done_q, power_q, prec_q;
    logic [4:0] dval_q;
    logic dbl_q, irqen_q, irq_q, halt_q;
    logic [7:0] map_q, pend_q, fwd_q;
    adcc_pkg::adcc_result_s res_q;

    logic aw_hs, w_hs, ar_hs, wr_fire, wr_en, wr_ok;
    logic rd_ok;
    logic [7:0] rd_byte;
    logic conv_start, tick, sar_busy, sar_done, sar_abort;
    adcc_pkg::adcc_result_s sar_res;

    function automatic logic [9:0] word_idx(input logic [11:0] addr);
        return addr[11:2];
    endfunction : word_idx

    function automatic logic is_mapped(input logic [9:0] idx);
        return idx == adcc_pkg::IDX_CLOCK || idx == adcc_pkg::IDX_CTRL
            || idx == adcc_pkg::IDX_RES_LO || idx == adcc_pkg::IDX_RES_HI
            || idx == adcc_pkg::IDX_MAP || idx == adcc_pkg::IDX_IRQ_EN
            || idx == adcc_pkg::IDX_SPEED;
    endfunction : is_mapped

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign sampled_input = chan_q;
    assign input_enable_bits = map_q;
    assign converter_power_on = power_q;
    assign conv_irq = irq_q;
    assign cpu_halt = halt_q;
    assign other_irq_fwd = fwd_q;

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    assign aw_hs = s_axi_awvalid && awready_q;
    assign w_hs = s_axi_wvalid && wready_q;
    assign ar_hs = s_axi_arvalid && arready_q;
    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
    assign wr_ok = is_mapped(aw_idx_q);
    // only byte lane 0 carries register bits
    assign wr_en = wr_fire && wr_ok && wlane_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            aw_idx_q <= 10'h000;
            wbyte_q <= 8'h00;
            wlane_q <= 1'b0;
        end else begin
            if (aw_hs) begin
                aw_held_q <= 1'b1;
                aw_idx_q <= word_idx(s_axi_awaddr);
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
            if (w_hs) begin
                w_held_q <= 1'b1;
                wbyte_q <= s_axi_wdata[7:0];
                wlane_q <= s_axi_wstrb[0];
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
            awready_q <= !(aw_hs || (aw_held_q && !wr_fire));
            wready_q <= !(w_hs || (w_held_q && !wr_fire));
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= adcc_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? adcc_pkg::RESP_OKAY : adcc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_comb begin
        logic [9:0] idx;
        idx = word_idx(s_axi_araddr);
        rd_ok = 1'b1;
        rd_byte = 8'h00;
        if (idx == adcc_pkg::IDX_CTRL) begin
            rd_byte = {1'b0, prec_q, power_q, done_q, start_q, sel_q};
        end else if (idx == adcc_pkg::IDX_CLOCK) begin
            rd_byte = {3'h0, dval_q};
        end else if (idx == adcc_pkg::IDX_RES_HI) begin
            rd_byte = res_q.upper;
        end else if (idx == adcc_pkg::IDX_RES_LO) begin
            rd_byte = {6'h00, res_q.lower};
        end else if (idx == adcc_pkg::IDX_MAP) begin
            rd_byte = map_q;
        end else if (idx == adcc_pkg::IDX_IRQ_EN) begin
            rd_byte = {6'h00, irqen_q, 1'b0};
        end else if (idx == adcc_pkg::IDX_SPEED) begin
            rd_byte = {7'h00, dbl_q};
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= adcc_pkg::RESP_OKAY;
        end else begin
            if (ar_hs) begin
                rvalid_q <= 1'b1;
                rdata_q <= {24'h00_0000, rd_byte};
                rresp_q <= rd_ok ? adcc_pkg::RESP_OKAY
                    : adcc_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
            arready_q <= !(ar_hs || (rvalid_q && !s_axi_rready));
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dval_q <= adcc_pkg::DIV_RST;
            dbl_q <= 1'b0;
            irqen_q <= 1'b0;
            map_q <= adcc_pkg::MAP_RST;
        end else if (wr_en) begin
            if (aw_idx_q == adcc_pkg::IDX_CLOCK) begin
                dval_q <= wbyte_q[4:0];
            end else if (aw_idx_q == adcc_pkg::IDX_SPEED) begin
                dbl_q <= wbyte_q[adcc_pkg::SPEED_DBL];
            end else if (aw_idx_q == adcc_pkg::IDX_IRQ_EN) begin
                irqen_q <= wbyte_q[adcc_pkg::IRQEN_CONV];
            end else if (aw_idx_q == adcc_pkg::IDX_MAP) begin
                map_q <= wbyte_q;
            end
        end
    end

    // ------------------------------------------------------------
    // conversion control
    // ------------------------------------------------------------
    logic ctrl_wr;
    assign ctrl_wr = wr_en && aw_idx_q == adcc_pkg::IDX_CTRL;
    // launch needs power and a mapped input; otherwise nothing moves
    assign conv_start = ctrl_wr && wbyte_q[adcc_pkg::CTRL_START]
        && !start_q && wbyte_q[adcc_pkg::CTRL_POWER]
        && map_q[wbyte_q[2:0]];
    // dropping power mid-conversion abandons it
    assign sar_abort = sar_busy && !power_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_q <= adcc_pkg::SEL_RST;
            power_q <= 1'b0;
            prec_q <= 1'b0;
            chan_q <= adcc_pkg::SEL_RST;
        end else begin
            if (ctrl_wr) begin
                sel_q <= wbyte_q[2:0];
                power_q <= wbyte_q[adcc_pkg::CTRL_POWER];
                prec_q <= wbyte_q[adcc_pkg::CTRL_PREC];
            end
            // the mux follows the select only at launch
            if (conv_start) begin
                chan_q <= wbyte_q[2:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_q <= 1'b0;
        end else if (conv_start) begin
            start_q <= 1'b1;
        end else if (sar_done || sar_abort) begin
            start_q <= 1'b0;
        end
    end

    // set wins over a clearing write in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_q <= 1'b0;
            res_q <= '0;
        end else if (sar_done) begin
            done_q <= 1'b1;
            res_q <= sar_res;
        end else if (ctrl_wr && !wbyte_q[adcc_pkg::CTRL_DONE]) begin
            done_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= done_q && irqen_q;
        end
    end

    // without the interrupt enabled the halt only ends at reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            halt_q <= 1'b0;
        end else if (conv_start && wbyte_q[adcc_pkg::CTRL_PREC]) begin
            halt_q <= 1'b1;
        end else if (irq_q) begin
            halt_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_q <= 8'h00;
            fwd_q <= 8'h00;
        end else if (halt_q) begin
            pend_q <= pend_q | other_irq_req;
            fwd_q <= 8'h00;
        end else begin
            pend_q <= 8'h00;
            fwd_q <= other_irq_req | pend_q;
        end
    end

    adcc_prescaler u_prescaler (
        .aclk(aclk),
        .aresetn(aresetn),
        .restart(conv_start),
        .dval(dval_q),
        .dbl(dbl_q),
        .tick(tick)
    );

    adcc_sar u_sar (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(conv_start),
        .abort(sar_abort),
        .tick(tick),
        .precision(wbyte_q[adcc_pkg::CTRL_PREC]),
        .comp_above(comp_above),
        .busy(sar_busy),
        .done(sar_done),
        .result(sar_res),
        .trial_code(trial_code),
        .sample_hold(sample_hold)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic [3:0] tick_cnt_q;
    always_ff @(posedge aclk) begin
        if (!aresetn || conv_start) begin
            tick_cnt_q <= 4'h0;
        end else if (tick && start_q) begin
            tick_cnt_q <= tick_cnt_q + 4'h1;
        end
    end

    start_launch_a: assert property (conv_start |=> start_q && sar_busy)
        else $error("start did not launch");
    start_clear_a: assert property (sar_done |=> !start_q)
        else $error("start bit not cleared");
    done_sticky_a: assert property (done_q && !ctrl_wr |=> done_q)
        else $error("done flag lost");
    irq_follow_a: assert property (done_q && irqen_q |=> irq_q)
        else $error("interrupt missing");
    chan_hold_a: assert property (start_q |=> $stable(chan_q))
        else $error("channel moved mid-run");
    blocked_start_a: assert property (ctrl_wr && !map_q[wbyte_q[2:0]]
        && !start_q |=> !start_q && $stable(res_q))
        else $error("unmapped start acted");
    conv_length_a: assert property (sar_done |-> tick_cnt_q == 4'hb)
        else $error("wrong conversion length");
    halt_entry_a: assert property (conv_start
        && wbyte_q[adcc_pkg::CTRL_PREC] |=> halt_q [*2])
        else $error("cpu not halted");
    halt_exit_a: assert property ($fell(halt_q) |-> $past(irq_q))
        else $error("halt left without wake");
    irq_held_a: assert property (halt_q |=> fwd_q == 8'h00)
        else $error("interrupt leaked in halt");
    std_bits_a: assert property (sar_done && !prec_q
        |=> res_q.lower == 2'h0)
        else $error("standard result too wide");
    result_pair_a: assert property (!$stable(res_q)
        |-> $past(sar_done))
        else $error("result changed alone");
    standby_a: assert property (!power_q && sar_busy |=> !sar_busy)
        else $error("standby kept converting");

    prec_run_c: cover property (conv_start
        && wbyte_q[adcc_pkg::CTRL_PREC] ##[1:1000] sar_done);
    std_run_c: cover property (conv_start
        && !wbyte_q[adcc_pkg::CTRL_PREC] ##[1:1000] sar_done);
    blocked_c: cover property (ctrl_wr && wbyte_q[adcc_pkg::CTRL_START]
        && !map_q[wbyte_q[2:0]]);
    pend_c: cover property (halt_q && other_irq_req != 8'h00);
endmodule : adcc_top

// ==== logic/adcc_pkg.sv ====
// adcc_pkg: shared constants and types for the converter control block.
// assumes a 10 MHz bus clock and an AXI4-Lite register bus.
package adcc_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned SETUP_TIME_NS = 4000;
    localparam int unsigned SETUP_CYCLES =
        (SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CONV_TICKS = 11;
    localparam logic [7:0] DIV_STD_MAX = 8'h80;
    localparam logic [7:0] DIV_DBL_MAX = 8'h40;
    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam int unsigned AXI_AW = 12;
    localparam logic [9:0] IDX_CLOCK = 10'h0f2;
    localparam logic [9:0] IDX_CTRL = 10'h0f3;
    localparam logic [9:0] IDX_RES_LO = 10'h0f4;
    localparam logic [9:0] IDX_RES_HI = 10'h0f5;
    localparam logic [9:0] IDX_MAP = 10'h0f6;
    localparam logic [9:0] IDX_IRQ_EN = 10'h0e8;
    localparam logic [9:0] IDX_SPEED = 10'h08e;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned CTRL_START = 3;
    localparam int unsigned CTRL_DONE = 4;
    localparam int unsigned CTRL_POWER = 5;
    localparam int unsigned CTRL_PREC = 6;
    localparam int unsigned IRQEN_CONV = 1;
    localparam int unsigned SPEED_DBL = 0;
    localparam logic [7:0] MAP_RST = 8'h00;
    localparam logic [4:0] DIV_RST = 5'h00;
    localparam logic [2:0] SEL_RST = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] upper;
        logic [1:0] lower;
    } adcc_result_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_SAMPLE = 3'h2,
        ST_CONVERT = 3'h4
    } adcc_state_e;

    // converter clock divisor in bus clocks
    function automatic logic [7:0] adcc_divisor(input logic [4:0] dval,
                                                input logic dbl);
        if (dval == 5'h00) begin
            return dbl ? DIV_DBL_MAX : DIV_STD_MAX;
        end
        return dbl ? {2'h0, dval, 1'h0} : {1'h0, dval, 2'h0};
    endfunction : adcc_divisor
endpackage : adcc_pkg

// ==== logic/adcc_prescaler.sv ====
// adcc_prescaler: one-cycle tick at the converter clock rate.
// assumes restart is pulsed when a conversion is launched.
`timescale 1ns/1ps
module adcc_prescaler (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic restart,
    input wire logic [4:0] dval,
    input wire logic dbl,
    output logic tick
);
    logic [7:0] cnt_q;
    logic tick_q;
    logic [7:0] div;

    assign div = adcc_pkg::adcc_divisor(dval, dbl);
    assign tick = tick_q;

    // restart aligns the first period to the launch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 8'h00;
            tick_q <= 1'b0;
        end else if (restart) begin
            cnt_q <= 8'h00;
            tick_q <= 1'b0;
        end else if (cnt_q == div - 8'h01) begin
            cnt_q <= 8'h00;
            tick_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 8'h01;
            tick_q <= 1'b0;
        end
    end
endmodule : adcc_prescaler

// ==== logic/adcc_sar.sv ====
// adcc_sar: successive approximation sequencer.
// assumes an outside comparator reports the held input against trial_code.
`timescale 1ns/1ps
module adcc_sar (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic abort,
    input wire logic tick,
    input wire logic precision,
    input wire logic comp_above,
    output logic busy,
    output logic done,
    output adcc_pkg::adcc_result_s result,
    output logic [9:0] trial_code,
    output logic sample_hold
);
    adcc_pkg::adcc_state_e state_q;
    logic [3:0] bit_q;
    logic [9:0] code_q;
    logic [9:0] code_d;
    logic prec_q;
    logic sh_q;
    logic done_q;
    adcc_pkg::adcc_result_s res_q;

    assign busy = (state_q != adcc_pkg::ST_IDLE);
    assign done = done_q;
    assign result = res_q;
    assign trial_code = code_q;
    assign sample_hold = sh_q;

    // keep or drop the trial bit, then try the next one down
    always_comb begin
        code_d = code_q;
        code_d[bit_q] = comp_above;
        if (bit_q != 4'h0) begin
            code_d[bit_q - 4'h1] = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= adcc_pkg::ST_IDLE;
            bit_q <= 4'h0;
            code_q <= 10'h000;
            prec_q <= 1'b0;
            sh_q <= 1'b0;
            done_q <= 1'b0;
            res_q <= '0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                adcc_pkg::ST_IDLE: begin
                    if (start) begin
                        state_q <= adcc_pkg::ST_SAMPLE;
                        prec_q <= precision;
                        sh_q <= 1'b1;
                        code_q <= 10'h000;
                    end
                end
                adcc_pkg::ST_SAMPLE: begin
                    if (abort) begin
                        state_q <= adcc_pkg::ST_IDLE;
                        sh_q <= 1'b0;
                    end else if (tick) begin
                        state_q <= adcc_pkg::ST_CONVERT;
                        sh_q <= 1'b0;
                        bit_q <= 4'h9;
                        code_q <= 10'h200;
                    end
                end
                adcc_pkg::ST_CONVERT: begin
                    if (abort) begin
                        state_q <= adcc_pkg::ST_IDLE;
                    end else if (tick) begin
                        code_q <= code_d;
                        if (bit_q == 4'h0) begin
                            state_q <= adcc_pkg::ST_IDLE;
                            done_q <= 1'b1;
                            // standard mode keeps only eight bits
                            res_q <= prec_q ? code_d
                                : {code_d[9:2], 2'h0};
                        end else begin
                            bit_q <= bit_q - 4'h1;
                        end
                    end
                end
                default: begin
                    state_q <= adcc_pkg::ST_IDLE;
                end
            endcase
        end
    end
endmodule : adcc_sar

// ==== dv/adcc_afe_model.sv ====
// adcc_afe_model: analog mux, sample-hold and comparator of the converter.
// assumes each input n carries a fixed level; input 7 sits above reference.
`timescale 1ns/1ps
module adcc_afe_model (
    input wire logic aclk,
    input wire logic sample_hold,
    input wire logic [2:0] sampled_input,
    input wire logic [9:0] trial_code,
    input wire logic converter_power_on,
    output logic comp_above
);
    // ------------------------------------------------------------
    // held level and comparator
    // ------------------------------------------------------------
    logic [9:0] held_q = 10'h000;
    logic junk_q = 1'b0;

    always @(posedge aclk) begin
        if (sample_hold) begin
            // over-range input clips to full scale
            held_q <= (sampled_input == 3'h7) ? 10'h3ff
                                              : {sampled_input, 7'h2b};
        end
        junk_q <= ~junk_q;
    end

    // a core in standby gives no valid decision, so the line wanders
    assign comp_above = converter_power_on ? (held_q >= trial_code)
                                           : junk_q;
endmodule : adcc_afe_model

// ==== dv/adc_conversion_control_tb_top.sv ====
// testbench: register-level checks of the converter control block.
// assumes adcc_top with the analog side modelled by adcc_afe_model.
`timescale 1ns/1ps
module adc_conversion_control_tb_top;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam logic [11:0] A_CLK = 12'h3c8, A_CTRL = 12'h3cc;
    localparam logic [11:0] A_LO = 12'h3d0, A_HI = 12'h3d4;
    localparam logic [11:0] A_MAP = 12'h3d8, A_IEN = 12'h3a0, A_SPD = 12'h238;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic [7:0] other_req = 8'h00, fwd, enb, d;
    logic [1:0] bresp, rresp, rsp;
    logic awready, wready, bvalid, arready, rvalid, comp, pwr, irq, halt, sh;
    logic [9:0] trial, e;
    logic [2:0] chsel;
    int fails = 0, cmp_count = 0;

    always #50 aclk = ~aclk;

    adcc_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .comp_above(comp), .other_irq_req(other_req), .trial_code(trial),
        .sample_hold(sh), .sampled_input(chsel), .input_enable_bits(enb),
        .converter_power_on(pwr), .conv_irq(irq), .cpu_halt(halt),
        .other_irq_fwd(fwd));

    adcc_afe_model afe_u (.aclk(aclk), .sample_hold(sh),
        .sampled_input(chsel), .trial_code(trial),
        .converter_power_on(pwr), .comp_above(comp));

    // ------------------------------------------------------------
    // bus tasks and checks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        cmp_count++;
        if (g !== x) begin
            fails++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        logic b;
        b = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                b = 1'b1;
                rsp = bresp;
                bready <= 1'b0;
            end
        end
    endtask : wr

    task automatic rd(input logic [11:0] a);
        logic b;
        b = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!b) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                b = 1'b1;
                d = rdata[7:0];
                rsp = rresp;
                rready <= 1'b0;
            end
        end
    endtask : rd

    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        results();
    end

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(A_MAP);
        chk(d, adcc_pkg::MAP_RST);
        rd(12'h000);
        chk({6'h0, rsp}, {6'h0, adcc_pkg::RESP_SLVERR});
        wr(12'h000, 8'h00);
        chk({6'h0, rsp}, {6'h0, adcc_pkg::RESP_SLVERR});
        $display("test reset done");
        wr(A_CLK, 8'h01);
        chk({6'h0, rsp}, {6'h0, adcc_pkg::RESP_OKAY});
        wr(A_CTRL, 8'h20);
        repeat (40) @(posedge aclk);
        chk({7'h0, pwr}, 8'h01);
        wr(A_MAP, 8'hf7);
        chk(enb, 8'hf7);
        wr(A_CTRL, 8'h2b);
        rd(A_CTRL);
        chk(d, 8'h23);
        wr(A_MAP, 8'hff);
        // divisor 4: done lands near 46 cycles after launch
        for (int c = 0; c < 8; c++) begin
            e = (c == 7) ? 10'h3ff : {c[2:0], 7'h2b};
            wr(A_CTRL, 8'h28 | c[7:0]);
            chk({5'h0, chsel}, c[7:0]);
            chk({7'h0, sh}, 8'h01);
            rd(A_CTRL);
            chk(d, 8'h28 | c[7:0]);
            repeat (30) @(posedge aclk);
            rd(A_CTRL);
            chk({7'h0, d[4]}, 8'h00);
            for (int i = 0; i < 30 && d[4] !== 1'b1; i++) rd(A_CTRL);
            chk(d, 8'h30 | c[7:0]);
            chk(trial[7:0], e[7:0]);
            rd(A_HI);
            chk(d, e[9:2]);
            rd(A_LO);
            chk(d, 8'h00);
        end
        $display("test standard done");
        wr(A_IEN, 8'h02);
        wr(A_CTRL, 8'h20);
        wr(A_CTRL, 8'h25);
        wr(A_CTRL, 8'h6d);
        chk({7'h0, halt}, 8'h01);
        other_req <= 8'h04;
        repeat (2) @(posedge aclk);
        chk(fwd, 8'h00);
        for (int i = 0; i < 80 && irq !== 1'b1; i++) @(posedge aclk);
        chk({7'h0, irq}, 8'h01);
        repeat (3) @(posedge aclk);
        chk({7'h0, halt}, 8'h00);
        chk(fwd, 8'h04);
        rd(A_HI);
        chk(d, 8'haa);
        rd(A_LO);
        chk(d, 8'h03);
        repeat (20) @(posedge aclk);
        rd(A_CTRL);
        chk(d, 8'h75);
        wr(A_CTRL, 8'h65);
        repeat (3) @(posedge aclk);
        chk({7'h0, irq}, 8'h00);
        $display("test precision done");
        wr(A_CTRL, 8'h2a);
        wr(A_CTRL, 8'h02);
        rd(A_CTRL);
        chk(d, 8'h02);
        rd(A_HI);
        chk(d, 8'haa);
        wr(A_SPD, 8'h01);
        wr(A_CTRL, 8'h20);
        repeat (40) @(posedge aclk);
        wr(A_CTRL, 8'h2a);
        // divisor 2: done by 24 cycles, divisor 4 would need 46
        repeat (24) @(posedge aclk);
        rd(A_CTRL);
        chk(d, 8'h32);
        rd(A_HI);
        chk(d, 8'h4a);
        $display("test power and speed done");
        results();
    end
endmodule : adc_conversion_control_tb_top
